// ===== npic_pkg.sv
// shared constants and types of the nested priority interrupt controller
package npic_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_VEC    = 14;
  localparam int NUM_EXT    = 4;
  localparam int EXT_PINS   = 4;
  localparam int NUM_PERIPH = 9;
  localparam int NUM_PRIO   = 4;

  // ****************************************
  // software priority codes
  // ****************************************
  localparam logic [1:0] LVL_0 = 2'h2;
  localparam logic [1:0] LVL_1 = 2'h1;
  localparam logic [1:0] LVL_2 = 2'h0;
  localparam logic [1:0] LVL_3 = 2'h3;

  // condition code bit positions of the level
  localparam int CC_I1_POS = 5;
  localparam int CC_I0_POS = 3;

  // ****************************************
  // vectors
  // ****************************************
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP  = 16'hFFFC;
  localparam logic [15:0] VEC_BASE  = 16'hFFFA;
  localparam logic [15:0] VEC_LOW   = 16'hFFE0;
  localparam logic [3:0]  VEC_TLI   = 4'h0;
  localparam logic [3:0]  VEC_EXT0  = 4'h2;
  localparam logic [3:0]  VEC_PER0  = 4'h1;
  localparam logic [3:0]  VEC_PER1  = 4'h6;
  // vectors that may leave deep stop
  localparam logic [13:0] WAKE_MASK = 14'h00FF;

  // ****************************************
  // priority registers
  // ****************************************
  localparam logic [7:0] PRIO_RESET = 8'hFF;
  localparam int         PRIO_FIELDS = 4;
  // fields of the last register holding real vectors
  localparam int         PRIO_LAST_FIELDS = 2;

  // source of the current entry
  typedef enum logic [1:0] {
    SRC_RESET = 2'b00,
    SRC_TRAP  = 2'b01,
    SRC_TLI   = 2'b10,
    SRC_MASK  = 2'b11
  } npic_src_t;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_RUN   = 2'b01,
    ST_STACK = 2'b10,
    ST_LOAD  = 2'b11
  } npic_state_t;

endpackage

// ===== npic_edge_latch.sv
// edge detector and request latch for one external interrupt line
`timescale 1ns/10ps
`default_nettype none

module npic_edge_latch #(
  parameter int W = 4
) (
  input  wire logic         core_clk,  // core clock
  input  wire logic         srst,      // sync reset
  input  wire logic [W-1:0] pins,      // line pins
  input  wire logic [W-1:0] sel,       // pin selects
  input  wire logic         rise,      // 1 rising, 0 falling
  input  wire logic         clr,       // entry clear
  output logic              pend       // latched request
);

  logic prev_r;
  logic prev_nxt;
  logic armed_r;
  logic armed_nxt;
  logic pend_r;
  logic pend_nxt;
  logic lvl;
  logic edge_seen;

  always_comb begin
    lvl       = rise ? |(pins & sel) : ~|(pins & sel);
    edge_seen = armed_r & lvl & ~prev_r;
    prev_nxt  = lvl;
    armed_nxt = 1'b1;
    // latch, cleared on entry; a new edge wins
    pend_nxt  = edge_seen | (pend_r & ~clr);
    if (srst) begin
      prev_nxt  = 1'b0;
      armed_nxt = 1'b0;
      pend_nxt  = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    prev_r  <= prev_nxt;
    armed_r <= armed_nxt;
    pend_r  <= pend_nxt;
  end

  assign pend = pend_r;

endmodule

`default_nettype wire

// ===== npic_prio_regs.sv
// per-vector software priority registers
`timescale 1ns/10ps
`default_nettype none

module npic_prio_regs (
  input  wire logic        core_clk,  // core clock
  input  wire logic        srst,      // sync reset
  input  wire logic        wr_en,     // write strobe
  input  wire logic [1:0]  idx,       // register index
  input  wire logic [7:0]  wr_data,   // write data
  output logic      [7:0]  rd_data,   // read data
  output logic      [27:0] prio_flat  // field per vector
);

  logic [7:0] regs_r   [npic_pkg::NUM_PRIO];
  logic [7:0] regs_nxt [npic_pkg::NUM_PRIO];
  logic [7:0] rd_r;
  logic [7:0] rd_nxt;

  always_comb begin
    for (int r = 0; r < npic_pkg::NUM_PRIO; r++) begin
      regs_nxt[r] = regs_r[r];
      for (int f = 0; f < npic_pkg::PRIO_FIELDS; f++) begin
        // level 0 write keeps old field
        if (wr_en && idx == r[1:0] && wr_data[2*f+:2] != npic_pkg::LVL_0 &&
            (r < npic_pkg::NUM_PRIO - 1 || f < npic_pkg::PRIO_LAST_FIELDS)) begin
          regs_nxt[r][2*f+:2] = wr_data[2*f+:2];
        end
      end
      if (srst) begin
        regs_nxt[r] = npic_pkg::PRIO_RESET;
      end
    end
    rd_nxt = srst ? npic_pkg::PRIO_RESET : regs_r[idx];
  end

  always_ff @(posedge core_clk) begin
    for (int r = 0; r < npic_pkg::NUM_PRIO; r++) begin
      regs_r[r] <= regs_nxt[r];
    end
    rd_r <= rd_nxt;
  end

  assign rd_data   = rd_r;
  assign prio_flat = {regs_r[3][3:0], regs_r[2], regs_r[1], regs_r[0]};

endmodule

`default_nettype wire

// ===== npic_ctrl.sv
// nested priority interrupt controller beside an 8-bit core
`timescale 1ns/10ps
`default_nettype none

// Operation
// - four levels coded 10, 01, 00, 11 from lowest to highest
// - fourteen fixed vectors at top of memory ordered by hardware priority
// - current level shown as condition code bits 5 and 3
// - maskable service begins only at the end of the current instruction; a latched trap is taken at once
// - entry requests stacking of PC, X, A and condition codes
// - maskable entry loads level from the vector's stored priority
// - after stacking, the program counter loads the vector address
// - interrupt return restores the stacked level
// - highest software priority wins, ties go to hardware order
// - unserved requests stay latched until they become highest
// - top-level pin, reset and trap rank above all software levels
// - reset and trap ignore the level, set level 3; reset stacks nothing
// - only vectors 0 to 7 (WAKE_MASK) can wake the core from deep stop
// - trap instruction raises trap; top-level pin can preempt it
// - maskable served only when enabled and above current level
// - top-level pin edge raises a request served like trap
// - edge requests latch and clear on service entry
// - selected pins of one line are ORed together
// - peripheral request needs both flag and enable
// - peripheral clear sequence discards its pending latch
// - any request wakes idle; only wake-capable ones wake deep stop
// - after deep stop, first service is wake-capable
// - level 0 writes to a priority field are ignored
module npic_ctrl (
  input  wire logic        core_clk,        // core clock
  input  wire logic        srst,            // sync reset
  input  wire logic        tli_pin,         // top-level pin
  input  wire logic        tli_rise,        // top-level edge select
  input  wire logic [15:0] ext_pins,        // 4 lines x 4 pins
  input  wire logic [15:0] ext_sel,         // pin selects
  input  wire logic [3:0]  ext_rise,        // edge select per line
  input  wire logic [8:0]  periph_flag,     // peripheral status flags
  input  wire logic [8:0]  periph_en,       // peripheral enables
  input  wire logic [8:0]  periph_clr,      // clear sequence pulses
  input  wire logic        prio_wr_en,      // priority write strobe
  input  wire logic [1:0]  prio_idx,        // priority register index
  input  wire logic [7:0]  prio_wr_data,    // priority write data
  output logic      [7:0]  prio_rd_data,    // priority read data
  input  wire logic        instr_done,      // instruction boundary
  input  wire logic        trap_exec,       // trap instruction done
  input  wire logic        interrupt_return_instr_exec,       // return instruction done
  input  wire logic [1:0]  interrupt_return_instr_level,      // level popped by return
  input  wire logic        cc_wr_en,        // level set by software
  input  wire logic [1:0]  cc_wr_level,     // level from software
  input  wire logic        stack_done,      // core finished stacking
  input  wire logic        wait_mode,       // core in idle wait
  input  wire logic        halt_mode,       // core in deep stop
  output logic             stack_req,       // stack context request
  output logic             pc_load,         // load vector pulse
  output logic      [15:0] vector_addr,     // vector to load
  output logic      [3:0]  serviced_vec,    // maskable vector taken
  output logic             priority_level_high_bit, // level bit 1
  output logic             priority_level_low_bit,  // level bit 0
  output logic             wake_wait,       // leave idle wait
  output logic             wake_halt,       // leave deep stop
  output logic      [13:0] pending          // latched requests
);

  // ****************************************
  // helpers
  // ****************************************
  // level code to rank
  // rank 0..3 from level code
  function automatic logic [2:0] lvl_rank(input logic [1:0] code);
    unique case (code)
      npic_pkg::LVL_0: lvl_rank = 3'h0;
      npic_pkg::LVL_1: lvl_rank = 3'h1;
      npic_pkg::LVL_2: lvl_rank = 3'h2;
      npic_pkg::LVL_3: lvl_rank = 3'h3;
    endcase
  endfunction

  function automatic logic [3:0] periph_vec(input int j);
    periph_vec = (j == 0) ? npic_pkg::VEC_PER0 : 4'(npic_pkg::VEC_PER1 + 4'(j - 1));
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  npic_pkg::npic_state_t state_r;
  npic_pkg::npic_state_t state_nxt;
  npic_pkg::npic_src_t   src_r;
  npic_pkg::npic_src_t   src_nxt;

  logic [1:0]  level_r;
  logic [1:0]  level_nxt;
  logic [3:0]  vec_r;
  logic [3:0]  vec_nxt;
  logic [15:0] addr_r;
  logic [15:0] addr_nxt;
  logic        trap_pend_r;
  logic        trap_pend_nxt;
  logic        tli_active_r;
  logic        tli_active_nxt;
  logic        post_halt_r;
  logic        post_halt_nxt;
  logic        wake_wait_r;
  logic        wake_wait_nxt;
  logic        wake_halt_r;
  logic        wake_halt_nxt;
  logic        stack_r;
  logic        stack_nxt;
  logic        load_r;
  logic        load_nxt;
  logic [8:0]  per_pend_r;
  logic [8:0]  per_pend_nxt;

  logic [27:0] prio_flat;
  logic [13:0] pend;
  logic [13:0] elig;
  logic [13:0] clr_vec;
  logic [3:0]  ext_pend;
  logic        tli_pend;
  logic        any_elig;
  logic [3:0]  best_vec;
  logic [2:0]  best_rank;
  logic [2:0]  cur_rank;
  logic [2:0]  rank_i;
  logic        take;

  // ****************************************
  // request sources
  // ****************************************
  // top-level pin edge latch
  npic_edge_latch #(
    .W (1)
  ) u_tli (
    .core_clk (core_clk),
    .srst     (srst),
    .pins     (tli_pin),
    .sel      (1'b1),
    .rise     (tli_rise),
    .clr      (clr_vec[0]),
    .pend     (tli_pend)
  );

  genvar g;
  generate
    for (g = 0; g < npic_pkg::NUM_EXT; g++) begin : gen_ext
      npic_edge_latch #(
        .W (npic_pkg::EXT_PINS)
      ) u_ext (
        .core_clk (core_clk),
        .srst     (srst),
        .pins     (ext_pins[4*g+:4]),
        .sel      (ext_sel[4*g+:4]),
        .rise     (ext_rise[g]),
        .clr      (clr_vec[npic_pkg::VEC_EXT0 + g]),
        .pend     (ext_pend[g])
      );
    end
  endgenerate

  npic_prio_regs u_prio (
    .core_clk  (core_clk),
    .srst      (srst),
    .wr_en     (prio_wr_en),
    .idx       (prio_idx),
    .wr_data   (prio_wr_data),
    .rd_data   (prio_rd_data),
    .prio_flat (prio_flat)
  );

  always_comb begin
    per_pend_nxt = (per_pend_r & ~periph_clr) | (periph_flag & periph_en);
    if (srst) begin
      per_pend_nxt = 9'h000;
    end
  end

  always_comb begin
    pend = 14'h0000;
    pend[0] = tli_pend;
    for (int e = 0; e < npic_pkg::NUM_EXT; e++) begin
      pend[npic_pkg::VEC_EXT0 + e] = ext_pend[e];
    end
    for (int j = 0; j < npic_pkg::NUM_PERIPH; j++) begin
      pend[periph_vec(j)] = per_pend_r[j];
    end
  end

  // ****************************************
  // arbitration
  // ****************************************
  always_comb begin
    cur_rank  = lvl_rank(level_r);
    elig      = 14'h0000;
    best_vec  = 4'h0;
    best_rank = 3'h0;
    rank_i    = 3'h0;
    any_elig  = 1'b0;
    for (int i = npic_pkg::NUM_VEC - 1; i >= 0; i--) begin
      // top-level pin ranks above level 3
      rank_i = (i == 0) ? 3'h4 : lvl_rank(prio_flat[2*i+:2]);
      // top-level pin may preempt trap handler
      elig[i] = pend[i] & ((i == 0) ? ~tli_active_r : (rank_i > cur_rank));
      // only wake-capable right after deep stop
      if (post_halt_r && !npic_pkg::WAKE_MASK[i]) begin
        elig[i] = 1'b0;
      end
      // higher rank wins, ties to lower vector
      if (elig[i] && (!any_elig || rank_i >= best_rank)) begin
        best_vec  = 4'(i);
        best_rank = rank_i;
        any_elig  = 1'b1;
      end
    end
  end

  // ****************************************
  // entry sequence
  // ****************************************
  always_comb begin
    state_nxt      = state_r;
    src_nxt        = src_r;
    level_nxt      = level_r;
    vec_nxt        = vec_r;
    addr_nxt       = addr_r;
    stack_nxt      = 1'b0;
    load_nxt       = 1'b0;
    clr_vec        = 14'h0000;
    take           = 1'b0;
    post_halt_nxt  = post_halt_r;
    tli_active_nxt = tli_active_r;
    trap_pend_nxt  = trap_pend_r | trap_exec;
    unique case (state_r)
      npic_pkg::ST_RESET: begin
        src_nxt   = npic_pkg::SRC_RESET;
        addr_nxt  = npic_pkg::VEC_RESET;
        level_nxt = npic_pkg::LVL_3;
        load_nxt  = 1'b1;
        state_nxt = npic_pkg::ST_LOAD;
      end
      npic_pkg::ST_RUN: begin
        if (interrupt_return_instr_exec) begin
          level_nxt      = interrupt_return_instr_level;
          tli_active_nxt = 1'b0;
        end else if (cc_wr_en) begin
          level_nxt = cc_wr_level;
        end
        // latched trap taken at once; maskable take only at an instruction boundary
        if (trap_pend_r) begin
          take          = 1'b1;
          trap_pend_nxt = trap_exec;
          src_nxt       = npic_pkg::SRC_TRAP;
          addr_nxt      = npic_pkg::VEC_TRAP;
        end else if (instr_done && any_elig && !trap_exec) begin
          take     = 1'b1;
          vec_nxt  = best_vec;
          src_nxt  = (best_vec == npic_pkg::VEC_TLI) ? npic_pkg::SRC_TLI
                                                     : npic_pkg::SRC_MASK;
          addr_nxt = 16'(npic_pkg::VEC_BASE - {11'h000, best_vec, 1'b0});
          clr_vec[best_vec] = 1'b1;
          post_halt_nxt     = 1'b0;
          if (best_vec == npic_pkg::VEC_TLI) begin
            tli_active_nxt = 1'b1;
          end
        end
        // no take (no latched trap, nothing eligible at a boundary) leaves the state in ST_RUN with no stack request
        if (take) begin
          stack_nxt = 1'b1;
          state_nxt = npic_pkg::ST_STACK;
        end
      end
      npic_pkg::ST_STACK: begin
        stack_nxt = ~stack_done;
        if (stack_done) begin
          // maskable level from its priority field
          level_nxt = (src_r == npic_pkg::SRC_MASK) ? prio_flat[2*vec_r+:2]
                                                    : npic_pkg::LVL_3;
          load_nxt  = 1'b1;
          state_nxt = npic_pkg::ST_LOAD;
        end
      end
      npic_pkg::ST_LOAD: begin
        state_nxt = npic_pkg::ST_RUN;
      end
    endcase
    // remember the deep stop exit; set beats the clear at take
    if (wake_halt_nxt) begin
      post_halt_nxt = 1'b1;
    end
    if (srst) begin
      state_nxt      = npic_pkg::ST_RESET;
      src_nxt        = npic_pkg::SRC_RESET;
      level_nxt      = npic_pkg::LVL_3;
      vec_nxt        = 4'h0;
      addr_nxt       = npic_pkg::VEC_RESET;
      stack_nxt      = 1'b0;
      load_nxt       = 1'b0;
      trap_pend_nxt  = 1'b0;
      tli_active_nxt = 1'b0;
      post_halt_nxt  = 1'b0;
    end
  end

  // ****************************************
  // low power wake
  // ****************************************
  always_comb begin
    wake_wait_nxt = wait_mode & (|pend);
    // deep stop only by wake-capable sources
    wake_halt_nxt = halt_mode & (|(pend & npic_pkg::WAKE_MASK));
    if (srst) begin
      wake_wait_nxt = 1'b0;
      wake_halt_nxt = 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // state is registered only; all decisions above
  always_ff @(posedge core_clk) begin
    state_r      <= state_nxt;
    src_r        <= src_nxt;
    level_r      <= level_nxt;
    vec_r        <= vec_nxt;
    addr_r       <= addr_nxt;
    stack_r      <= stack_nxt;
    load_r       <= load_nxt;
    trap_pend_r  <= trap_pend_nxt;
    tli_active_r <= tli_active_nxt;
    post_halt_r  <= post_halt_nxt;
    wake_wait_r  <= wake_wait_nxt;
    wake_halt_r  <= wake_halt_nxt;
    per_pend_r   <= per_pend_nxt;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign stack_req    = stack_r;
  assign pc_load      = load_r;
  assign vector_addr  = addr_r;
  assign serviced_vec = vec_r;
  // level bits as held in condition codes
  assign priority_level_high_bit = level_r[1];
  assign priority_level_low_bit  = level_r[0];
  assign wake_wait    = wake_wait_r;
  assign wake_halt    = wake_halt_r;
  assign pending      = pend;

endmodule

`default_nettype wire

// ===== npic_ctrl_assertions.sv
// port-level assertion checker of the interrupt controller
`timescale 1ns/10ps
`default_nettype none

module npic_ctrl_assertions (
  input wire logic        core_clk,                // core clock
  input wire logic        srst,                    // sync reset
  input wire logic        instr_done,              // instruction boundary
  input wire logic        trap_exec,               // trap done
  input wire logic        interrupt_return_instr_exec,               // return done
  input wire logic [1:0]  interrupt_return_instr_level,              // popped level
  input wire logic        cc_wr_en,                // software level write
  input wire logic        stack_done,              // stacking finished
  input wire logic        stack_req,               // stacking request
  input wire logic        pc_load,                 // vector load pulse
  input wire logic [15:0] vector_addr,             // vector address
  input wire logic [3:0]  serviced_vec,            // vector taken
  input wire logic        priority_level_high_bit, // level bit 1
  input wire logic        priority_level_low_bit   // level bit 0
);
  // ****************************************
  // helpers
  // ****************************************
  logic [1:0] lvl;
  logic       trap_r;
  logic       trap_nxt;
  assign lvl = {priority_level_high_bit, priority_level_low_bit};

  // a trap waits latched while an entry is in flight, so remember it
  always_comb begin
    trap_nxt = trap_r;
    if (trap_exec) begin
      trap_nxt = 1'b1;
    end else if (pc_load && vector_addr == 16'hFFFC) begin
      trap_nxt = 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    trap_r <= srst ? 1'b0 : trap_nxt;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_stack_wait;
    stack_req && !stack_done;
  endsequence
  sequence s_stack_end;
    stack_req && stack_done;
  endsequence

  // ****************************************
  // assertions
  // ****************************************
  // reset entry
  AST_RESET_VEC: assert property (
    $fell(srst) |=> pc_load && vector_addr == 16'hFFFE && lvl == 2'h3)
    else $error("reset entry wrong");
  AST_STACK_HOLD: assert property (
    s_stack_wait |=> stack_req && !pc_load) else $error("stack request dropped");
  AST_STACK_LOAD: assert property (
    s_stack_end |=> !stack_req && pc_load) else $error("no vector load");
  AST_LOAD_CAUSE: assert property (
    $rose(pc_load) && vector_addr != 16'hFFFE |-> $past(stack_req && stack_done))
    else $error("load without stacking");
  AST_PC_PULSE: assert property (
    pc_load |=> !pc_load) else $error("load pulse too long");
  AST_VEC_MAP: assert property (
    pc_load && vector_addr < 16'hFFFC |->
      vector_addr == 16'hFFFA - {11'h000, serviced_vec, 1'b0})
    else $error("vector address mismatch");
  AST_NMI_LVL: assert property (
    pc_load && vector_addr >= 16'hFFFA |-> lvl == 2'h3) else $error("level not 3");
  AST_TAKE_CAUSE: assert property (
    $rose(stack_req) |-> $past(instr_done) || $past(trap_exec) || $past(trap_r))
    else $error("entry off boundary");
  AST_INTERRUPT_RETURN_INSTR_LVL: assert property (
    interrupt_return_instr_exec && !stack_req && !pc_load && !$fell(srst) |=> lvl == $past(interrupt_return_instr_level))
    else $error("return level lost");
  AST_LVL_STABLE: assert property (
    !interrupt_return_instr_exec && !cc_wr_en |=> $stable(lvl) || pc_load) else $error("level moved");
endmodule

bind npic_ctrl npic_ctrl_assertions u_chk (
  .core_clk, .srst, .instr_done, .trap_exec, .interrupt_return_instr_exec, .interrupt_return_instr_level, .cc_wr_en,
  .stack_done, .stack_req, .pc_load, .vector_addr, .serviced_vec,
  .priority_level_high_bit, .priority_level_low_bit
);
`default_nettype wire

// ===== npic_core_model.sv
// behavioural core that answers stacking requests after a set delay
`timescale 1ns/10ps
`default_nettype none

module npic_core_model (
  input  wire logic       core_clk,   // core clock
  input  wire logic       srst,       // sync reset
  input  wire logic       stack_req,  // stacking request
  input  wire logic [3:0] dly,        // answer delay in cycles
  output logic            stack_done  // stacking finished pulse
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       done_nxt;

  always_comb begin
    cnt_nxt  = cnt_r + 4'h1;
    done_nxt = 1'b0;
    if (!stack_req || stack_done) begin
      cnt_nxt = 4'h0;
    end else if (cnt_r == dly) begin
      done_nxt = 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    cnt_r      <= srst ? 4'h0 : cnt_nxt;
    stack_done <= !srst && done_nxt;
  end
endmodule
`default_nettype wire

// ===== tb_npic_ctrl.sv
// self-checking bench of the nested priority interrupt controller
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
  miscompares++; $display("FAIL %s expected %0h seen %0h", nm, exp, got); end end

module tb_npic_ctrl;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        tli_pin = 1'b0;
  logic        tli_rise = 1'b1;
  logic [15:0] ext_pins = 16'h0000;
  logic [15:0] ext_sel = 16'h0000;
  logic [3:0]  ext_rise = 4'hF;
  logic [8:0]  periph_flag = 9'h000;
  logic [8:0]  periph_en = 9'h000;
  logic [8:0]  periph_clr = 9'h000;
  logic        prio_wr_en = 1'b0;
  logic [1:0]  prio_idx = 2'h0;
  logic [7:0]  prio_wr_data = 8'h00;
  logic        instr_done = 1'b0;
  logic        trap_exec = 1'b0;
  logic        interrupt_return_instr_exec = 1'b0;
  logic [1:0]  interrupt_return_instr_level = 2'h0;
  logic        cc_wr_en = 1'b0;
  logic [1:0]  cc_wr_level = 2'h0;
  logic        wait_mode = 1'b0;
  logic        halt_mode = 1'b0;
  logic [3:0]  dly = 4'h0;
  logic        stack_done, stack_req, pc_load, wake_wait, wake_halt;
  logic        priority_level_high_bit, priority_level_low_bit;
  logic [7:0]  prio_rd_data;
  logic [15:0] vector_addr;
  logic [3:0]  serviced_vec;
  logic [13:0] pending;
  logic [1:0]  lvl;
  int          miscompares = 0;
  int          num_checks = 0;
  logic [15:0] exp_va [3] = '{16'hFFF6, 16'hFFF8, 16'hFFF4};
  logic [1:0]  exp_lv [3] = '{npic_pkg::LVL_2, npic_pkg::LVL_1, npic_pkg::LVL_1};

  assign lvl = {priority_level_high_bit, priority_level_low_bit};
  always #25 core_clk = ~core_clk;

  npic_ctrl DUT (
    .core_clk, .srst, .tli_pin, .tli_rise, .ext_pins, .ext_sel, .ext_rise,
    .periph_flag, .periph_en, .periph_clr, .prio_wr_en, .prio_idx, .prio_wr_data,
    .prio_rd_data, .instr_done, .trap_exec, .interrupt_return_instr_exec, .interrupt_return_instr_level, .cc_wr_en,
    .cc_wr_level, .stack_done, .wait_mode, .halt_mode, .stack_req, .pc_load,
    .vector_addr, .serviced_vec, .priority_level_high_bit, .priority_level_low_bit,
    .wake_wait, .wake_halt, .pending
  );
  npic_core_model u_core (.core_clk, .srst, .stack_req, .dly, .stack_done);

  // ****************************************
  // tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic pulse_done();
    instr_done = 1'b1;
    cyc(1);
    instr_done = 1'b0;
  endtask
  // bounded wait: a lost entry shows as an entry check failure, not a hang
  task automatic expect_entry(input logic [15:0] va, input logic [1:0] lv);
    int n;
    n = 0;
    while (pc_load !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    `CHK("entry", 1'b1, pc_load)
    `CHK("vector", va, vector_addr)
    `CHK("level", lv, lvl)
    cyc(1);
  endtask
  task automatic prio_wr(input logic [1:0] i, input logic [7:0] d);
    prio_idx = i;
    prio_wr_data = d;
    prio_wr_en = 1'b1;
    cyc(1);
    prio_wr_en = 1'b0;
    cyc(1);
  endtask
  task automatic prio_chk(input logic [1:0] i, input logic [7:0] d);
    prio_idx = i;
    cyc(2);
    `CHK("prio", d, prio_rd_data)
  endtask
  task automatic lvl_set(input logic [1:0] l);
    cc_wr_en = 1'b1;
    cc_wr_level = l;
    cyc(1);
    cc_wr_en = 1'b0;
    cyc(1);
  endtask
  task automatic interrupt_return_instr(input logic [1:0] l);
    interrupt_return_instr_exec = 1'b1;
    interrupt_return_instr_level = l;
    cyc(1);
    interrupt_return_instr_exec = 1'b0;
    cyc(1);
    `CHK("interrupt_return_instr level", l, lvl)
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    cyc(6);
    srst = 1'b0;
    expect_entry(16'hFFFE, npic_pkg::LVL_3);
    prio_chk(2'h0, 8'hFF);
    prio_wr(2'h3, 8'h00);
    prio_chk(2'h3, 8'hF0);
    prio_wr(2'h0, 8'hCF);
    prio_wr(2'h0, 8'h64);
    prio_chk(2'h0, 8'h44);
    $display("test priority registers done");
    periph_flag[0] = 1'b1;
    cyc(2);
    `CHK("pend v1", 1'b0, pending[1])
    periph_en[0] = 1'b1;
    cyc(2);
    `CHK("pend v1", 1'b1, pending[1])
    pulse_done();
    cyc(3);
    `CHK("stack", 1'b0, stack_req)
    periph_flag[0] = 1'b0;
    cyc(1);
    `CHK("pend v1", 1'b1, pending[1])
    periph_clr[0] = 1'b1;
    cyc(1);
    periph_clr[0] = 1'b0;
    cyc(1);
    `CHK("pend v1", 1'b0, pending[1])
    $display("test peripheral latch done");
    lvl_set(npic_pkg::LVL_0);
    dly = 4'h3;
    periph_flag[0] = 1'b1;
    ext_sel = 16'h0031;
    cyc(2);
    ext_pins = 16'h0021;
    cyc(2);
    `CHK("pending", 14'h000E, pending)
    cyc(3);
    `CHK("stack", 1'b0, stack_req)
    for (int k = 0; k < 3; k++) begin
      pulse_done();
      expect_entry(exp_va[k], exp_lv[k]);
      if (k == 0) `CHK("pend v2", 1'b0, pending[2])
      if (k == 1) begin
        periph_flag[0] = 1'b0;
        periph_clr[0] = 1'b1;
        cyc(1);
        periph_clr[0] = 1'b0;
      end
      interrupt_return_instr(npic_pkg::LVL_0);
    end
    `CHK("pending", 14'h0000, pending)
    ext_pins = 16'h0000;
    dly = 4'h0;
    $display("test nested order done");
    lvl_set(npic_pkg::LVL_3);
    trap_exec = 1'b1;
    cyc(1);
    trap_exec = 1'b0;
    expect_entry(16'hFFFC, npic_pkg::LVL_3);
    tli_pin = 1'b1;
    cyc(2);
    `CHK("pend tli", 1'b1, pending[0])
    pulse_done();
    expect_entry(16'hFFFA, npic_pkg::LVL_3);
    tli_pin = 1'b0;
    interrupt_return_instr(npic_pkg::LVL_3);
    interrupt_return_instr(npic_pkg::LVL_0);
    $display("test trap and top pin done");
    periph_en[3] = 1'b1;
    periph_flag[3] = 1'b1;
    wait_mode = 1'b1;
    cyc(2);
    `CHK("wake wait", 1'b1, wake_wait)
    wait_mode = 1'b0;
    halt_mode = 1'b1;
    cyc(2);
    `CHK("wake halt", 1'b0, wake_halt)
    ext_pins[0] = 1'b1;
    cyc(2);
    `CHK("wake halt", 1'b1, wake_halt)
    halt_mode = 1'b0;
    pulse_done();
    expect_entry(16'hFFF6, npic_pkg::LVL_2);
    pulse_done();
    expect_entry(16'hFFEA, npic_pkg::LVL_3);
    $display("test wake done");
    summarize();
  end

  initial begin
    #(3000 * 50);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
